//--- inc/cps_pkg.sv
// Constants shared by the cycling preset sequencer
`default_nettype none
package cps_pkg;
  localparam int NSET = 4;
  localparam int IW = 2;
  localparam int GW = 12;
  localparam int RW = 16;
  localparam int BW = 3;
  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_EDIT = 8'h08;
  localparam logic [7:0] A_PGAIN = 8'h0C;
  localparam logic [7:0] A_PCOL = 8'h10;
  localparam logic [7:0] A_PROI = 8'h14;
  localparam logic [7:0] A_PBIN = 8'h18;
  localparam logic [7:0] A_POUT = 8'h1C;
  localparam logic [7:0] A_PART = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_BGAIN = 8'h28;
  localparam logic [7:0] A_BROI = 8'h2C;
  localparam logic [7:0] A_BBIN = 8'h30;
  localparam logic [7:0] A_BCOL = 8'h34;
  localparam logic [7:0] A_CMD = 8'h38;
  // CTRL fields
  localparam int C_EN = 0;
  localparam int C_COL = 1;
  localparam int C_AWB = 3;
  localparam int C_ABR = 4;
  localparam int C_LATCH = 5;
  localparam int C_ADV = 8;
  localparam int C_REW = 12;
  // CFG fields
  localparam int F_TOT = 0;
  localparam int F_DIV = 8;
  // POUT fields
  localparam int O_SEL = 0;
  localparam int O_SRC = 4;
  localparam int O_LVL = 8;
  // Participation bits
  localparam int P_GAIN = 0;
  localparam int P_WB = 1;
  localparam int P_ROI = 2;
  localparam int P_BIN = 3;
  localparam int P_OUT = 4;
  // CMD bits
  localparam int K_STROBE = 0;
  localparam int K_ADV = 1;
  localparam int K_REW = 2;
  // Advance events
  localparam logic [2:0] ADV_FRAME = 3'h0;
  localparam logic [2:0] ADV_TRIG = 3'h1;
  localparam logic [2:0] ADV_TIMER = 3'h2;
  localparam logic [2:0] ADV_PIN = 3'h3;
  localparam logic [2:0] ADV_SOFT = 3'h4;
  // Rewind events
  localparam logic [1:0] REW_OFF = 2'h0;
  localparam logic [1:0] REW_ACQ = 2'h1;
  localparam logic [1:0] REW_PIN = 2'h2;
  localparam logic [1:0] REW_SOFT = 2'h3;
  // Output sources and pin numbers
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_HOST = 2'h1;
  localparam logic [1:0] SRC_PULSE = 2'h2;
  localparam logic [1:0] SRC_EXPO = 2'h3;
  localparam logic [2:0] PIN_FIRST = 3'h3;
  // Reset values
  localparam logic [GW-1:0] GAIN_RST = 12'h100;
  localparam logic [BW-1:0] BIN_RST = 3'h1;
  localparam logic [3:0] TOT_RST = 4'h1;
  localparam logic [7:0] DIV_RST = 8'h01;
endpackage
`default_nettype wire

//--- rtl/cps_seq.sv
// Cycling preset sequencer with AHB-Lite register slave
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none
module cps_seq import cps_pkg::*; (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pipeline events, on hclk
  input wire logic frame_begin_event,
  input wire logic accepted_frame_trigger,
  input wire logic timer_expiry_event,
  input wire logic acquisition_finish_event,
  input wire logic exposure_begin,
  input wire logic exposure_on,
  // Asynchronous input pin
  input wire logic input_pin_event,
  // Applied settings
  output logic [GW-1:0] applied_amplification,
  output logic [GW-1:0] applied_gain_red,
  output logic [GW-1:0] applied_gain_green,
  output logic [GW-1:0] applied_gain_blue,
  output logic [RW-1:0] applied_roi_x,
  output logic [RW-1:0] applied_roi_y,
  output logic [BW-1:0] applied_bin_x,
  output logic [BW-1:0] applied_bin_y,
  // Output pins, high closes the circuit
  output logic output_pin_a,
  output logic output_pin_b,
  output logic output_pin_c,
  output logic [IW-1:0] active_set_index
);
  logic [31:0] ctrl_q, cfg_q, part_q;
  logic [IW-1:0] edit_q, idx_q;
  logic [7:0] rep_q, addr_q;
  logic wr_q, rd_q, rdw_q, pend_q;
  logic [31:0] rdata_q;
  logic [NSET-1:0][GW-1:0] pgain_q;
  logic [NSET-1:0][2:0][GW-1:0] pcol_q;
  logic [NSET-1:0][2*RW-1:0] proi_q;
  logic [NSET-1:0][2*BW-1:0] pbin_q;
  logic [NSET-1:0][8:0] pout_q;
  logic [NSET-1:0] drv_q;
  logic [GW-1:0] bgain_q;
  logic [2:0][GW-1:0] bcol_q;
  logic [2*RW-1:0] broi_q;
  logic [2*BW-1:0] bbin_q;
  logic pin_s1_q, pin_s2_q, pin_s3_q;
  logic [2:0] pin_q;
  logic [GW-1:0] amp_q;
  logic [2:0][GW-1:0] col_q;
  logic [2*RW-1:0] roi_q;
  logic [2*BW-1:0] bin_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus decode
  wire addr_ph = hsel & hready & htrans[1];
  wire wr_en = wr_q;
  wire sel_ctrl = wr_en & (addr_q == A_CTRL);
  wire sel_cfg = wr_en & (addr_q == A_CFG);
  wire sel_edit = wr_en & (addr_q == A_EDIT);
  wire sel_pgain = wr_en & (addr_q == A_PGAIN);
  wire sel_pcol = wr_en & (addr_q == A_PCOL);
  wire sel_proi = wr_en & (addr_q == A_PROI);
  wire sel_pbin = wr_en & (addr_q == A_PBIN);
  wire sel_pout = wr_en & (addr_q == A_POUT);
  wire sel_part = wr_en & (addr_q == A_PART);
  wire sel_bgain = wr_en & (addr_q == A_BGAIN);
  wire sel_broi = wr_en & (addr_q == A_BROI);
  wire sel_bbin = wr_en & (addr_q == A_BBIN);
  wire sel_bcol = wr_en & (addr_q == A_BCOL);
  wire sel_cmd = wr_en & (addr_q == A_CMD);

  // Control fields
  wire seq_on = ctrl_q[C_EN];
  wire [1:0] col_sel = ctrl_q[C_COL+:2];
  wire latch_on = ctrl_q[C_LATCH];
  wire [2:0] adv_src = ctrl_q[C_ADV+:3];
  wire [1:0] rew_src = ctrl_q[C_REW+:2];
  wire [3:0] set_total = cfg_q[F_TOT+:4];
  wire [7:0] adv_div = cfg_q[F_DIV+:8];
  wire [3:0] last_idx = (set_total == 4'h0) ? 4'h0 : set_total - 4'h1;
  wire use_gain = seq_on & part_q[P_GAIN];
  wire use_wb = seq_on & part_q[P_WB] & ~ctrl_q[C_AWB] & ~ctrl_q[C_ABR];
  wire use_roi = seq_on & part_q[P_ROI];
  wire use_bin = seq_on & part_q[P_BIN];
  wire use_out = seq_on & part_q[P_OUT];
  wire col_ok = col_sel != 2'h3;

  // Software commands, one-cycle pulses
  wire sw_strobe = sel_cmd & hwdata[K_STROBE];
  wire sw_adv = sel_cmd & hwdata[K_ADV];
  wire sw_rew = sel_cmd & hwdata[K_REW];

  // Input pin edge after the two-stage synchroniser
  wire pin_rise = pin_s2_q & ~pin_s3_q;

  wire adv_sync = (adv_src == ADV_FRAME) | (adv_src == ADV_TRIG);
  wire adv_raw = (adv_src == ADV_FRAME) ? frame_begin_event :
                 (adv_src == ADV_TRIG) ? accepted_frame_trigger :
                 (adv_src == ADV_TIMER) ? timer_expiry_event :
                 (adv_src == ADV_PIN) ? pin_rise :
                 (adv_src == ADV_SOFT) ? sw_adv : 1'b0;
  wire rew_raw = (rew_src == REW_ACQ) ? acquisition_finish_event :
                 (rew_src == REW_PIN) ? pin_rise :
                 (rew_src == REW_SOFT) ? sw_rew : 1'b0;
  wire adv_ev = seq_on & adv_raw;
  wire rew_ev = seq_on & rew_raw;
  wire rew_now = rew_ev & ~adv_sync;
  wire rew_due = adv_sync & adv_ev & (pend_q | rew_ev);
  wire [7:0] rep_inc = rep_q + 8'h01;
  wire step = adv_ev & ~rew_due & (rep_inc >= adv_div);
  wire wrap = {2'b00, idx_q} >= last_idx;

  // Bus phase tracking; reads take one wait state so data comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      rdw_q <= 1'b0;
    end else begin
      if (hreadyout) begin
        addr_q <= haddr[7:0];
        wr_q <= addr_ph & hwrite & (haddr[31:8] == 24'h000000);
        rd_q <= addr_ph & ~hwrite;
      end
      rdw_q <= rd_q & ~rdw_q;
    end
  end

  assign hreadyout = ~(rd_q & ~rdw_q);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  wire [31:0] rd_mux =
    (addr_q == A_CTRL) ? ctrl_q :
    (addr_q == A_CFG) ? cfg_q :
    (addr_q == A_EDIT) ? {30'h0, edit_q} :
    (addr_q == A_PGAIN) ? {20'h0, pgain_q[edit_q]} :
    (addr_q == A_PCOL && col_ok) ? {20'h0, pcol_q[edit_q][col_sel]} :
    (addr_q == A_PROI) ? proi_q[edit_q] :
    (addr_q == A_PBIN) ? {16'h0, 5'h0, pbin_q[edit_q][BW+:BW], 5'h0, pbin_q[edit_q][0+:BW]} :
    (addr_q == A_POUT) ? {23'h0, pout_q[edit_q]} :
    (addr_q == A_PART) ? part_q :
    (addr_q == A_STAT) ? {13'h0, pin_q, rep_q, 5'h0, pend_q, idx_q} :
    (addr_q == A_BGAIN) ? {20'h0, bgain_q} :
    (addr_q == A_BROI) ? broi_q :
    (addr_q == A_BBIN) ? {16'h0, 5'h0, bbin_q[BW+:BW], 5'h0, bbin_q[0+:BW]} :
    (addr_q == A_BCOL && col_ok) ? {20'h0, bcol_q[col_sel]} : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdata_q <= 32'h0;
    else if (rd_q & ~rdw_q) rdata_q <= rd_mux;
  end

  // Global control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 32'h0;
      cfg_q <= {16'h0, DIV_RST, 4'h0, TOT_RST};
      part_q <= 32'h0;
      edit_q <= '0;
    end else begin
      if (sel_ctrl) ctrl_q <= hwdata & 32'h0000_373F;
      if (sel_cfg) cfg_q <= hwdata & 32'h0000_FF0F;
      if (sel_part) part_q <= hwdata & 32'h0000_001F;
      if (sel_edit) edit_q <= hwdata[IW-1:0];
    end
  end

  // Standard controls turn read only while their parameter cycles; colour gains also under auto mode while P_WB participates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bgain_q <= GAIN_RST;
      bcol_q <= {3{GAIN_RST}};
      broi_q <= 32'h0;
      bbin_q <= {BIN_RST, BIN_RST};
    end else begin
      if (sel_bgain & ~use_gain) bgain_q <= hwdata[GW-1:0];
      if (sel_bcol & ~(seq_on & part_q[P_WB]) & col_ok) begin
        bcol_q[col_sel] <= hwdata[GW-1:0];
      end
      if (sel_broi & ~use_roi) broi_q <= hwdata;
      if (sel_bbin & ~use_bin) bbin_q <= {hwdata[8+:BW], hwdata[0+:BW]};
    end
  end

  // Preset storage: writes only touch the edited preset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pgain_q <= {NSET{GAIN_RST}};
      pcol_q <= {(3*NSET){GAIN_RST}};
      proi_q <= '0;
      pbin_q <= {(2*NSET){BIN_RST}};
      pout_q <= '0;
    end else begin
      if (sel_pgain) pgain_q[edit_q] <= hwdata[GW-1:0];
      if (sel_pcol & col_ok) pcol_q[edit_q][col_sel] <= hwdata[GW-1:0];
      if (sel_proi) proi_q[edit_q] <= hwdata;
      if (sel_pbin) pbin_q[edit_q] <= {hwdata[8+:BW], hwdata[0+:BW]};
      if (sel_pout) pout_q[edit_q] <= hwdata[8:0];
    end
  end

  // Host-driven levels: direct, or held until the strobe when latched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) drv_q <= '0;
    else begin
      if (sel_pout & ~latch_on) drv_q[edit_q] <= hwdata[O_LVL];
      if (sw_strobe & latch_on) begin
        for (int i = 0; i < NSET; i++) drv_q[i] <= pout_q[i][O_LVL];
      end
    end
  end

  // Input pin synchroniser
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= input_pin_event;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  // Sequencer core
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_q <= '0;
      rep_q <= 8'h00;
      pend_q <= 1'b0;
    end else if (!seq_on || rew_now || rew_due) begin
      idx_q <= '0;
      rep_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      if (rew_ev) pend_q <= 1'b1;
      if (step) begin
        idx_q <= wrap ? '0 : idx_q + 1'b1;
        rep_q <= 8'h00;
      end else if (adv_ev) begin
        rep_q <= rep_inc;
      end
    end
  end

  // Applied settings, preset copy while cycling, standard otherwise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      amp_q <= GAIN_RST;
      col_q <= {3{GAIN_RST}};
      roi_q <= 32'h0;
      bin_q <= {BIN_RST, BIN_RST};
    end else begin
      amp_q <= use_gain ? pgain_q[idx_q] : bgain_q;
      col_q <= use_wb ? pcol_q[idx_q] : bcol_q;
      roi_q <= use_roi ? proi_q[idx_q] : broi_q;
      bin_q <= use_bin ? pbin_q[idx_q] : bbin_q;
    end
  end

  // Output pins; only the active preset's selected pin is driven
  wire [2:0] act_sel = pout_q[idx_q][O_SEL+:3];
  wire [1:0] act_src = pout_q[idx_q][O_SRC+:2];
  wire act_lvl = (act_src == SRC_HOST) ? drv_q[idx_q] :
                 (act_src == SRC_PULSE) ? exposure_begin :
                 (act_src == SRC_EXPO) ? exposure_on : 1'b0;
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_pin
      wire hit = use_out & (act_sel == PIN_FIRST + 3'(k));
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pin_q[k] <= 1'b0;
        else pin_q[k] <= hit & act_lvl;
      end
    end
  endgenerate

  assign output_pin_a = pin_q[0];
  assign output_pin_b = pin_q[1];
  assign output_pin_c = pin_q[2];
  assign active_set_index = idx_q;
  assign applied_amplification = amp_q;
  assign applied_gain_red = col_q[0];
  assign applied_gain_green = col_q[1];
  assign applied_gain_blue = col_q[2];
  assign applied_roi_x = roi_q[0+:RW];
  assign applied_roi_y = roi_q[RW+:RW];
  assign applied_bin_x = bin_q[0+:BW];
  assign applied_bin_y = bin_q[BW+:BW];

  // Checks

  sequence s_pulse_src;
    use_out && act_src == SRC_PULSE && act_sel == PIN_FIRST + 3'h1 && !rew_now && !step;
  endsequence

  async_rewind_a: assert property (rew_now |=> idx_q == '0 && rep_q == 8'h00)
    else $error("async rewind did not clear index");
  sync_rewind_a: assert property (seq_on && adv_sync && rew_ev && !adv_ev |=>
    pend_q && $stable(idx_q))
    else $error("sync rewind acted early");
  wrap_index_a: assert property (seq_on && step && wrap && !rew_now |=> idx_q == '0)
    else $error("index did not wrap");
  hold_index_a: assert property (seq_on && adv_ev && !rew_ev && !pend_q &&
    rep_inc < adv_div |=> $stable(idx_q) && rep_q == $past(rep_q) + 8'h01)
    else $error("index moved before divider count");
  base_gain_a: assert property (!use_gain |=> amp_q == $past(bgain_q))
    else $error("preset gain used while not cycling");
  pin_pulse_a: assert property (s_pulse_src ##0 exposure_begin |=> output_pin_b)
    else $error("no pulse on exposure begin");
  expo_level_a: assert property (use_out && act_src == SRC_EXPO &&
    act_sel == PIN_FIRST + 3'h2 |=> output_pin_c == $past(exposure_on))
    else $error("exposure level mismatch");
  read_only_a: assert property (sel_bgain && use_gain |=> $stable(bgain_q))
    else $error("read-only gain changed");
  auto_wb_a: assert property ((ctrl_q[C_AWB] || ctrl_q[C_ABR]) |=>
    col_q == $past(bcol_q))
    else $error("preset colour gain used with auto mode");
endmodule // cps_seq
`default_nettype wire

//--- verification/cps_host.sv
// Host-side AHB-Lite master model for the preset sequencer bench
`timescale 1ns/10ps
`default_nettype none
module cps_host (
  // Clock
  input wire logic hclk,
  // Slave answer
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Master request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Address phase held until taken, then data phase held until ready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
    // Released data bus must not look like the last word
    hwdata <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // cps_host
`default_nettype wire

//--- verification/cycling_preset_sequencer_bench.sv
// Self-checking bench for the cycling preset sequencer
`timescale 1ns/10ps
`default_nettype none
module cycling_preset_sequencer_bench import cps_pkg::*; ;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, expo_on;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] ev;
  logic [GW-1:0] amp, g_r, g_g, g_b;
  logic [RW-1:0] roi_x, roi_y;
  logic [BW-1:0] bin_x, bin_y;
  logic pin_a, pin_b, pin_c;
  logic [IW-1:0] idx;
  int failures, total_checks, cycles;
  int rk[3] = '{5, 3, 7};

  cps_seq dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .frame_begin_event(ev[0]), .accepted_frame_trigger(ev[1]),
    .timer_expiry_event(ev[2]), .acquisition_finish_event(ev[5]),
    .exposure_begin(ev[6]), .exposure_on(expo_on), .input_pin_event(ev[3]),
    .applied_amplification(amp), .applied_gain_red(g_r), .applied_gain_green(g_g),
    .applied_gain_blue(g_b), .applied_roi_x(roi_x), .applied_roi_y(roi_y),
    .applied_bin_x(bin_x), .applied_bin_y(bin_y), .output_pin_a(pin_a),
    .output_pin_b(pin_b), .output_pin_c(pin_c), .active_set_index(idx));
  cps_host host_u (.hclk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata);

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    ev = 7'h0;
    expo_on = 1'b0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
  end
  task automatic wrap_up;
    if (failures == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounds any hang in a handshake wait
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, s);
      failures++;
    end
  endtask
  // Four edges cover the pin synchroniser plus the output register
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] a, input logic [1:0] r,
      input logic [31:0] x);
    return {18'h0, r, 1'b0, a, 8'h0} | x | 32'h1;
  endfunction
  // Event codes follow the advance encoding; 5 finish, 6 exposure, 7 soft rewind
  task automatic fire(input int k);
    if (k == 4) host_u.wr(A_CMD, 32'h2);
    else if (k == 7) host_u.wr(A_CMD, 32'h4);
    else begin
      ev[k] <= 1'b1;
      repeat (k == 3 ? 5 : 1) @(posedge hclk);
      ev[k] <= 1'b0;
    end
  endtask

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("amp_rst", 32'(amp), 32'(GAIN_RST));
    chk("bin_rst", 32'(bin_x), 32'(BIN_RST));
    chk("idx_rst", 32'(idx), 32'h0);
    host_u.rd(A_CFG, d);
    chk("cfg_rst", d, {16'h0, DIV_RST, 4'h0, TOT_RST});
    host_u.rd(8'hFC, d);
    chk("unmapped", d, 32'h0);
    host_u.wr(A_CFG, 32'h0000_0104);
    for (int k = 0; k < 5; k++) begin
      host_u.wr(A_CTRL, cw(3'(k), REW_OFF, 32'h0));
      fire(k);
      settle();
      chk("adv_src", 32'(idx), 32'((k + 1) % 4));
    end
    host_u.wr(A_CTRL, 32'h0);
    host_u.wr(A_CFG, 32'h0000_0203);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h0));
    for (int i = 1; i < 8; i++) begin
      fire(4);
      settle();
      chk("wrap_idx", 32'(idx), 32'((i / 2) % 3));
      host_u.rd(A_STAT, d);
      chk("repeat_cnt", 32'(d[15:8]), 32'(i % 2));
    end
    host_u.wr(A_CTRL, 32'h0);
    host_u.wr(A_PART, 32'h0000_001F);
    for (int j = 0; j < 3; j++) begin
      host_u.wr(A_EDIT, 32'(j));
      host_u.wr(A_PGAIN, 32'h200 + 32'(j));
    end
    settle();
    chk("gain_off", 32'(amp), 32'(GAIN_RST));
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h0));
    settle();
    chk("gain_p0", 32'(amp), 32'h200);
    host_u.wr(A_EDIT, 32'h2);
    host_u.wr(A_PGAIN, 32'h3AA);
    host_u.wr(A_BGAIN, 32'h7FF);
    chk("hresp_ro", 32'(hresp), 32'h0);
    host_u.rd(A_BGAIN, d);
    chk("base_ro", d, 32'(GAIN_RST));
    settle();
    chk("gain_keep", 32'(amp), 32'h200);
    fire(4);
    fire(4);
    settle();
    chk("gain_p1", 32'(amp), 32'h201);
    host_u.wr(A_EDIT, 32'h1);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h2));
    host_u.wr(A_PCOL, 32'h0AB);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h4));
    host_u.wr(A_PCOL, 32'h0CD);
    // Selector code 3 names no colour, so this write must land nowhere
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h6));
    host_u.wr(A_PCOL, 32'h0FF);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h0));
    host_u.wr(A_PCOL, 32'h0EF);
    settle();
    chk("red", 32'(g_r), 32'h0EF);
    chk("green", 32'(g_g), 32'h0AB);
    chk("blue", 32'(g_b), 32'h0CD);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h8));
    settle();
    chk("green_auto", 32'(g_g), 32'(GAIN_RST));
    host_u.wr(A_PROI, 32'h0022_0011);
    host_u.wr(A_PBIN, 32'h0000_0402);
    settle();
    chk("roi", {roi_y, roi_x}, 32'h0022_0011);
    chk("bin", 32'({bin_y, bin_x}), 32'h22);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h0));
    host_u.wr(A_POUT, 32'h0000_0113);
    settle();
    chk("pin_host", 32'({pin_c, pin_b, pin_a}), 32'h1);
    host_u.wr(A_CTRL, cw(ADV_SOFT, REW_OFF, 32'h20));
    host_u.wr(A_CMD, 32'h1);
    host_u.wr(A_POUT, 32'h0000_0013);
    settle();
    chk("pin_held", 32'(pin_a), 32'h1);
    host_u.wr(A_CMD, 32'h1);
    settle();
    chk("pin_strobe", 32'(pin_a), 32'h0);
    host_u.wr(A_POUT, 32'h0000_0024);
    ev[6] <= 1'b1;
    @(posedge hclk);
    ev[6] <= 1'b0;
    @(posedge hclk);
    chk("pulse_hi", 32'({pin_c, pin_b, pin_a}), 32'h2);
    @(posedge hclk);
    chk("pulse_lo", 32'(pin_b), 32'h0);
    host_u.wr(A_POUT, 32'h0000_0105);
    settle();
    chk("pin_open", 32'({pin_c, pin_b, pin_a}), 32'h0);
    host_u.wr(A_POUT, 32'h0000_0035);
    expo_on <= 1'b1;
    settle();
    chk("expo_hi", 32'({pin_c, pin_b, pin_a}), 32'h4);
    expo_on <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("expo_lo", 32'(pin_c), 32'h0);
    host_u.wr(A_CFG, 32'h0000_0104);
    host_u.wr(A_CTRL, cw(ADV_FRAME, REW_ACQ, 32'h0));
    fire(5);
    settle();
    chk("rew_wait", 32'(idx), 32'h1);
    fire(0);
    settle();
    chk("rew_sync", 32'(idx), 32'h0);
    for (int r = 0; r < 3; r++) begin
      host_u.wr(A_CTRL, cw(ADV_TIMER, 2'(r + 1), 32'h0));
      fire(2);
      settle();
      chk("rew_pre", 32'(idx), 32'h1);
      fire(rk[r]);
      settle();
      chk("rew_async", 32'(idx), 32'h0);
    end
    // Reset in mid-run must drop the active preset and its applied gain
    fire(2);
    settle();
    chk("idx_pre_rst", 32'(idx), 32'h1);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("idx_mid_rst", 32'(idx), 32'h0);
    chk("amp_mid_rst", 32'(amp), 32'(GAIN_RST));
    host_u.rd(A_CTRL, d);
    chk("ctrl_mid_rst", d, 32'h0);
    wrap_up();
  end
endmodule // cycling_preset_sequencer_bench
`default_nettype wire
